// File: fslui_defines.vh
// Constants for the framed stream link user interface: block codes,
// field positions, reset values and pause timing.
// Assumes a 16-byte user word striped over two 66-bit lanes.
// How it works
// - Take transmit beat only when valid and ready
// - Invalid cycles inside frame send idle blocks
// - Only framed transmit words carry meaning
// - Optional CRC appended, count and end moved
// - Keep counts bytes only on last beat
// - Byte zero first, most significant bit first
// - Frame: data blocks, then separator, else idles
// - Every block: two-bit header plus eight bytes
// - Separator: type 1E, count, then bytes, or type 78 and seven bytes
// - Full last beat: separator next non-pause cycle, empty without CRC
// - Three pause cycles every 10,000 cycles
// - Frame data spread across all lanes
// - Receive strips control, idle, compensation blocks
// - Receive keep gives byte count with last
// - Receive side has no ready, no buffer
// - Receive valid may drop mid-frame
// - Ready low one cycle in every 32
`ifndef FSLUI_DEFINES_VH
`define FSLUI_DEFINES_VH

`define FSLUI_LANES        2
`define FSLUI_WORD_BYTES   16
`define FSLUI_HDR_DATA     2'b01
`define FSLUI_HDR_CTRL     2'b10
`define FSLUI_TYPE_SEP     8'h1e
`define FSLUI_TYPE_SEP7    8'h78
`define FSLUI_TYPE_IDLE    8'h10
`define FSLUI_TYPE_CC      8'h2d
`define FSLUI_SEP_MAX      6
`define FSLUI_SEP_CNT_LSB  8
`define FSLUI_SEP_DAT_LSB  16
`define FSLUI_SCR_SEED     58'h3ff_ffff_ffff_ffff
`define FSLUI_CRC_POLY     32'h04c1_1db7
`define FSLUI_CRC_INIT     32'hffff_ffff
`define FSLUI_CRC_BYTES    6'd4
`define FSLUI_GB_PERIOD    32
`define FSLUI_CC_LEN       3
`define FSLUI_CC_PERIOD    10000

`endif

// File: fslui_link_user_if.v
// Framing user interface: stream beats to striped 66-bit blocks and back.
// Assumes the lane blocks come from and go to logic on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
`include "fslui_defines.vh"

module fslui_link_user_if #(
  parameter        CRC_EN    = 0,
  parameter [13:0] CC_PERIOD = `FSLUI_CC_PERIOD
) (
  // Clock and reset
  input  wire         clk_sys_in,
  input  wire         reset_in,
  // Transmit stream from user
  input  wire [127:0] s_axi_tx_tdata_in,
  input  wire [15:0]  s_axi_tx_tkeep_in,
  input  wire         s_axi_tx_tlast_in,
  input  wire         s_axi_tx_tvalid_in,
  output wire         s_axi_tx_tready_out,
  // Transmit lanes, lane i at [66i+65:66i], header on top
  output wire [131:0] tx_blk_out,
  output reg          tx_blk_valid_out,
  // Receive lanes
  input  wire [131:0] rx_blk_in,
  input  wire         rx_blk_valid_in,
  // Receive stream to user, no ready
  output reg  [127:0] m_axi_rx_tdata_out,
  output reg  [15:0]  m_axi_rx_tkeep_out,
  output reg          m_axi_rx_tlast_out,
  output reg          m_axi_rx_tvalid_out
);

  localparam integer GB_LAST_I  = `FSLUI_GB_PERIOD - 1;
  localparam integer CC_START_I = CC_PERIOD - `FSLUI_CC_LEN;
  localparam [4:0]   GB_LAST    = GB_LAST_I[4:0];
  localparam [13:0]  CC_START   = CC_START_I[13:0];

  function [4:0] keep_count;
    input [15:0] keep;
    integer i;
    begin
      keep_count = 5'd0;
      for (i = 0; i < 16; i = i + 1)
        keep_count = keep_count + {4'h0, keep[i]};
    end
  endfunction

  function [15:0] keep_mask;
    input [4:0] n;
    integer i;
    begin
      keep_mask = 16'h0;
      for (i = 0; i < 16; i = i + 1)
        keep_mask[i] = (i < n);
    end
  endfunction

  function [127:0] byte_mask;
    input [4:0] n;
    integer i;
    begin
      byte_mask = 128'h0;
      for (i = 0; i < 16; i = i + 1)
        byte_mask[8*i+:8] = (i < n) ? 8'hff : 8'h00;
    end
  endfunction

  // CRC-32 over the first n bytes in line order
  function [31:0] crc_bytes;
    input [31:0]  crc_in;
    input [127:0] data;
    input [4:0]   n;
    integer i;
    integer b;
    begin
      crc_bytes = crc_in;
      for (i = 0; i < 16; i = i + 1)
        if (i < n)
          for (b = 7; b >= 0; b = b - 1)
            crc_bytes = {crc_bytes[30:0], 1'b0} ^
                        ((crc_bytes[31] ^ data[8*i+b]) ? `FSLUI_CRC_POLY : 32'h0);
    end
  endfunction

  // Pause timing
  reg  [4:0]  gb_cnt_r;
  reg  [13:0] cc_cnt_r;
  wire        gb_pause  = (gb_cnt_r == GB_LAST);
  wire        cc_active = (cc_cnt_r >= CC_START);

  // Transmit state
  reg         pend_r;
  reg  [2:0]  pend_cnt_r;
  reg  [31:0] pend_data_r;
  reg  [31:0] crc_r;
  reg         pend_nxt;
  reg  [2:0]  pend_cnt_nxt;
  reg  [31:0] pend_data_nxt;
  reg  [31:0] crc_nxt;
  reg  [3:0]  tx_hdr_nxt;
  reg  [127:0] tx_pl_nxt;
  reg  [3:0]  tx_hdr_r;
  wire [127:0] tx_scr;

  wire tx_ready  = ~gb_pause & ~cc_active & ~pend_r;
  wire tx_accept = s_axi_tx_tvalid_in & tx_ready;
  assign s_axi_tx_tready_out = tx_ready;

  wire [4:0]   tx_n    = keep_count(s_axi_tx_tkeep_in);
  wire [31:0]  tx_crc  = crc_bytes(crc_r, s_axi_tx_tdata_in, tx_n);
  wire [5:0]   tx_m    = {1'b0, tx_n} + ((CRC_EN != 0) ? `FSLUI_CRC_BYTES : 6'd0);
  // Last beat with CRC spliced in right after the final user byte
  wire [159:0] tx_ext  = {32'h0, s_axi_tx_tdata_in & byte_mask(tx_n)} |
                         ((CRC_EN != 0) ? ({128'h0, tx_crc} << {tx_n, 3'b000}) : 160'h0);
  wire [1:0]   tx_g    = tx_m[4:3];
  wire [2:0]   tx_r    = tx_m[2:0];
  wire [5:0]   tx_over = tx_m - 6'd16;

  integer i;
  integer b;

  always @* begin
    pend_nxt      = pend_r;
    pend_cnt_nxt  = pend_cnt_r;
    pend_data_nxt = pend_data_r;
    crc_nxt       = crc_r;
    for (i = 0; i < `FSLUI_LANES; i = i + 1) begin
      tx_hdr_nxt[2*i+:2] = `FSLUI_HDR_CTRL;
      tx_pl_nxt[64*i+:64] = {56'h0, `FSLUI_TYPE_IDLE};
    end
    if (gb_pause) begin
      // Gearbox slot: nothing leaves, scramblers hold
    end else if (cc_active) begin
      for (i = 0; i < `FSLUI_LANES; i = i + 1)
        tx_pl_nxt[64*i+:64] = {56'h0, `FSLUI_TYPE_CC};
    end else if (pend_r) begin
      tx_pl_nxt[63:0] = {16'h0, pend_data_r, 5'h0, pend_cnt_r, `FSLUI_TYPE_SEP};
      pend_nxt = 1'b0;
    end else if (tx_accept) begin
      if (!s_axi_tx_tlast_in) begin
        for (i = 0; i < `FSLUI_LANES; i = i + 1) begin
          tx_hdr_nxt[2*i+:2]  = `FSLUI_HDR_DATA;
          tx_pl_nxt[64*i+:64] = s_axi_tx_tdata_in[64*i+:64];
        end
        crc_nxt = crc_bytes(crc_r, s_axi_tx_tdata_in, 5'd16);
      end else begin
        crc_nxt = `FSLUI_CRC_INIT;
        if (tx_m >= 6'd16) begin
          // Word full: the separator follows on its own cycle
          for (i = 0; i < `FSLUI_LANES; i = i + 1) begin
            tx_hdr_nxt[2*i+:2]  = `FSLUI_HDR_DATA;
            tx_pl_nxt[64*i+:64] = tx_ext[64*i+:64];
          end
          pend_nxt      = 1'b1;
          pend_cnt_nxt  = tx_over[2:0];
          pend_data_nxt = tx_ext[159:128];
        end else begin
          for (i = 0; i < `FSLUI_LANES; i = i + 1) begin
            if (i < tx_g) begin
              tx_hdr_nxt[2*i+:2]  = `FSLUI_HDR_DATA;
              tx_pl_nxt[64*i+:64] = tx_ext[64*i+:64];
            end else if (i == tx_g) begin
              if (tx_r == 3'd7)
                tx_pl_nxt[64*i+:64] = {tx_ext[64*i+:56], `FSLUI_TYPE_SEP7};
              else
                tx_pl_nxt[64*i+:64] = {tx_ext[64*i+:48], 5'h0, tx_r, `FSLUI_TYPE_SEP};
            end
          end
        end
      end
    end
  end

  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      gb_cnt_r         <= 5'd0;
      cc_cnt_r         <= 14'd0;
      pend_r           <= 1'b0;
      pend_cnt_r       <= 3'd0;
      pend_data_r      <= 32'h0;
      crc_r            <= `FSLUI_CRC_INIT;
      tx_hdr_r         <= {`FSLUI_HDR_CTRL, `FSLUI_HDR_CTRL};
      tx_blk_valid_out <= 1'b0;
    end else begin
      gb_cnt_r         <= gb_cnt_r + 5'd1;
      cc_cnt_r         <= (cc_cnt_r == CC_PERIOD - 14'd1) ? 14'd0 : cc_cnt_r + 14'd1;
      pend_r           <= pend_nxt;
      pend_cnt_r       <= pend_cnt_nxt;
      pend_data_r      <= pend_data_nxt;
      crc_r            <= crc_nxt;
      if (!gb_pause)
        tx_hdr_r <= tx_hdr_nxt;
      tx_blk_valid_out <= ~gb_pause;
    end
  end

  // Receive pipeline stage
  reg  [3:0]   rx_hdr_r;
  reg          rx_v_r;
  wire [127:0] rx_pl;

  genvar gl;
  generate
    for (gl = 0; gl < `FSLUI_LANES; gl = gl + 1) begin : g_lane
      fslui_scrambler #(.DESCRAMBLE(0)) u_scr (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .en_in      (~gb_pause),
        .data_in    (tx_pl_nxt[64*gl+:64]),
        .data_out   (tx_scr[64*gl+:64])
      );
      fslui_scrambler #(.DESCRAMBLE(1)) u_dscr (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .en_in      (rx_blk_valid_in),
        .data_in    (rx_blk_in[66*gl+:64]),
        .data_out   (rx_pl[64*gl+:64])
      );
      assign tx_blk_out[66*gl+:66] = {tx_hdr_r[2*gl+:2], tx_scr[64*gl+:64]};
    end
  endgenerate

  // Collect frame bytes of one cycle; nothing follows a separator or idle
  reg [127:0] rx_bytes;
  reg [4:0]   rx_nb;
  reg         rx_end;
  reg         rx_stop;
  reg [7:0]   rx_type;
  reg [2:0]   rx_cnt;

  // Own loop index, so the transmit process stays the only writer of its one
  always @* begin : rx_collect
    integer i;
    i        = 0;
    rx_bytes = 128'h0;
    rx_nb    = 5'd0;
    rx_end   = 1'b0;
    rx_stop  = ~rx_v_r;
    rx_type  = 8'h0;
    rx_cnt   = 3'd0;
    for (i = 0; i < `FSLUI_LANES; i = i + 1) begin
      if (!rx_stop) begin
        rx_type = rx_pl[64*i+:8];
        if (rx_hdr_r[2*i+:2] == `FSLUI_HDR_DATA) begin
          rx_bytes[64*i+:64] = rx_pl[64*i+:64];
          rx_nb = rx_nb + 5'd8;
        end else if (rx_hdr_r[2*i+:2] == `FSLUI_HDR_CTRL &&
                     (rx_type == `FSLUI_TYPE_SEP || rx_type == `FSLUI_TYPE_SEP7)) begin
          if (rx_type == `FSLUI_TYPE_SEP7) begin
            rx_bytes[64*i+:56] = rx_pl[64*i+8+:56];
            rx_cnt = 3'd7;
          end else begin
            rx_cnt = (rx_pl[64*i+`FSLUI_SEP_CNT_LSB+:8] > `FSLUI_SEP_MAX) ?
                     3'd6 : rx_pl[64*i+`FSLUI_SEP_CNT_LSB+:3];
            for (b = 0; b < `FSLUI_SEP_MAX; b = b + 1)
              if (b < rx_cnt)
                rx_bytes[64*i+8*b+:8] = rx_pl[64*i+`FSLUI_SEP_DAT_LSB+8*b+:8];
          end
          rx_nb   = rx_nb + {2'b00, rx_cnt};
          rx_end  = 1'b1;
          rx_stop = 1'b1;
        end else begin
          rx_stop = 1'b1;
        end
      end
    end
  end

  // One beat is held back until it is known whether it ends the frame
  reg         hold_v_r;
  reg         hold_last_r;
  reg [127:0] hold_data_r;
  reg [4:0]   hold_cnt_r;
  reg         out_v_nxt;
  reg         out_last_nxt;

  always @* begin
    out_v_nxt    = 1'b0;
    out_last_nxt = 1'b0;
    if (rx_nb != 5'd0) begin
      out_v_nxt    = hold_v_r;
      out_last_nxt = hold_last_r;
    end else if (hold_v_r && (rx_end || hold_last_r)) begin
      out_v_nxt    = 1'b1;
      out_last_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rx_hdr_r            <= 4'h0;
      rx_v_r              <= 1'b0;
      hold_v_r            <= 1'b0;
      hold_last_r         <= 1'b0;
      hold_data_r         <= 128'h0;
      hold_cnt_r          <= 5'd0;
      m_axi_rx_tdata_out  <= 128'h0;
      m_axi_rx_tkeep_out  <= 16'h0;
      m_axi_rx_tlast_out  <= 1'b0;
      m_axi_rx_tvalid_out <= 1'b0;
    end else begin
      rx_v_r <= rx_blk_valid_in;
      if (rx_blk_valid_in)
        rx_hdr_r <= {rx_blk_in[131:130], rx_blk_in[65:64]};
      // No ready input: every beat goes out as soon as it is complete
      m_axi_rx_tvalid_out <= out_v_nxt;
      m_axi_rx_tlast_out  <= out_last_nxt;
      m_axi_rx_tdata_out  <= hold_data_r;
      m_axi_rx_tkeep_out  <= out_last_nxt ? keep_mask(hold_cnt_r) : 16'hffff;
      if (rx_nb != 5'd0) begin
        hold_v_r    <= 1'b1;
        hold_last_r <= rx_end;
        hold_data_r <= rx_bytes;
        hold_cnt_r  <= rx_nb;
      end else if (out_v_nxt) begin
        hold_v_r    <= 1'b0;
        hold_last_r <= 1'b0;
      end
    end
  end

endmodule // fslui_link_user_if
`default_nettype wire

// File: fslui_link_user_if_tb.sv
// Testbench for the link user interface with its lanes looped back.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "fslui_defines.vh"
module fslui_link_user_if_tb;
  logic         clk_sys_in   = 1'b0;
  logic         reset_in     = 1'b1;
  logic [127:0] tx_data      = 128'h0;
  logic [15:0]  tx_keep      = 16'h0;
  logic         tx_last      = 1'b0;
  logic         tx_valid     = 1'b0;
  logic [3:0]   hdr0         = 4'h0;
  logic         rdy_last     = 1'b0;
  int           fails        = 0;
  int           total_checks = 0;
  int           cycles       = 0;
  int           low_cnt      = 0;
  wire          tx_ready;
  wire  [131:0] blk;
  wire          blk_valid;
  wire  [127:0] rx_data;
  wire  [15:0]  rx_keep;
  wire          rx_last;
  wire          rx_valid;
  logic         crc_sel      = 1'b0;
  wire          crc_rdy;
  wire  [131:0] crc_blk;
  wire          crc_bv;
  wire  [127:0] crc_d;
  wire  [15:0]  crc_k;
  wire          crc_l;
  wire          crc_v;
  // Short compensation period so a frame crosses a pause
  fslui_link_user_if #(.CRC_EN(0), .CC_PERIOD(14'd40)) DUT (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .s_axi_tx_tdata_in(tx_data),
    .s_axi_tx_tkeep_in(tx_keep),
    .s_axi_tx_tlast_in(tx_last),
    .s_axi_tx_tvalid_in(tx_valid & ~crc_sel),
    .s_axi_tx_tready_out(tx_ready),
    .tx_blk_out(blk),
    .tx_blk_valid_out(blk_valid),
    .rx_blk_in(blk),
    .rx_blk_valid_in(blk_valid),
    .m_axi_rx_tdata_out(rx_data),
    .m_axi_rx_tkeep_out(rx_keep),
    .m_axi_rx_tlast_out(rx_last),
    .m_axi_rx_tvalid_out(rx_valid)
  );
  fslui_user_model u_user (
    .clk_sys_in(clk_sys_in),
    .rx_tdata_in(rx_data),
    .rx_tkeep_in(rx_keep),
    .rx_tlast_in(rx_last),
    .rx_tvalid_in(rx_valid)
  );
  // Same stimulus, steered here by crc_sel, with the CRC built in
  fslui_link_user_if #(.CRC_EN(1), .CC_PERIOD(14'd40)) DUT_CRC (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .s_axi_tx_tdata_in(tx_data),
    .s_axi_tx_tkeep_in(tx_keep),
    .s_axi_tx_tlast_in(tx_last),
    .s_axi_tx_tvalid_in(tx_valid & crc_sel),
    .s_axi_tx_tready_out(crc_rdy),
    .tx_blk_out(crc_blk),
    .tx_blk_valid_out(crc_bv),
    .rx_blk_in(crc_blk),
    .rx_blk_valid_in(crc_bv),
    .m_axi_rx_tdata_out(crc_d),
    .m_axi_rx_tkeep_out(crc_k),
    .m_axi_rx_tlast_out(crc_l),
    .m_axi_rx_tvalid_out(crc_v)
  );
  fslui_user_model u_crc (
    .clk_sys_in(clk_sys_in),
    .rx_tdata_in(crc_d),
    .rx_tkeep_in(crc_k),
    .rx_tlast_in(crc_l),
    .rx_tvalid_in(crc_v)
  );
  initial forever #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task check(input [127:0] seen, input [127:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask
  function [127:0] pat(input [7:0] b);
    integer k;
    for (k = 0; k < 16; k = k + 1) pat[8*k +: 8] = b + k[7:0];
  endfunction
  function [127:0] mask(input [15:0] k);
    integer j;
    for (j = 0; j < 16; j = j + 1) mask[8*j +: 8] = {8{k[j]}};
  endfunction
  // Reference CRC over the first n bytes, each byte bit 7 first
  function [31:0] crc_ref(input [31:0] c, input [127:0] d, input int n);
    integer q;
    crc_ref = c;
    for (q = 0; q < 8 * n; q = q + 1)
      crc_ref = {crc_ref[30:0], 1'b0} ^ ((crc_ref[31] ^ d[8*(q/8) + 7 - q%8]) ? `FSLUI_CRC_POLY : 32'h0);
  endfunction
  // Entered at a falling edge; returns at the falling edge after acceptance
  task send(input [127:0] d, input [15:0] k, input l);
    int  n;
    logic ok;
    begin
      tx_data = d;
      tx_keep = k;
      tx_last = l;
      tx_valid = 1'b1;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 50) begin
        ok = crc_sel ? crc_rdy : tx_ready;
        if (!ok) low_cnt = low_cnt + 1;
        @(negedge clk_sys_in);
        n = n + 1;
      end
    end
  endtask
  task frame(input [7:0] b0, input int n, input [15:0] k, input gap);
    int i;
    int s;
    logic [127:0] m;
    begin
      s = u_user.rx_cnt;
      for (i = 0; i < n; i = i + 1) begin
        send(pat(b0 + 8'(i * 16)), k, i == n - 1);
        if (i == 0) hdr0 = {blk[131:130], blk[65:64]};
        if (i == n - 1) rdy_last = tx_ready;
        if (gap) begin
          tx_valid = 1'b0;
          @(negedge clk_sys_in);
        end
      end
      tx_valid = 1'b0;
      i = 0;
      while (u_user.rx_cnt < s + n && i < 200) begin
        @(negedge clk_sys_in);
        i = i + 1;
      end
      check(u_user.rx_cnt, s + n);
      for (i = 0; i < n; i = i + 1) begin
        m = (i == n - 1) ? mask(k) : {128{1'b1}};
        check(u_user.rx_data[s+i] & m, pat(b0 + 8'(i * 16)) & m);
        check(u_user.rx_keep[s+i], (i == n - 1) ? k : 16'hffff);
        check(u_user.rx_last[s+i], i == n - 1);
      end
    end
  endtask
  task test_full;
    begin
      frame(8'h00, 2, 16'hffff, 1'b0);
      check(hdr0, 4'h5);
      check(rdy_last, 1'b0);
    end
  endtask
  task test_gap;
    frame(8'h40, 3, 16'h000f, 1'b1);
  endtask
  // Byte totals that take every separator form, short and long
  task test_keeps;
    logic [15:0] kt [0:4];
    int i;
    begin
      kt = '{16'h0001, 16'h007f, 16'h00ff, 16'h0fff, 16'h7fff};
      for (i = 0; i < 5; i = i + 1) frame(8'h20 + 8'(i), 1, kt[i], 1'b0);
    end
  endtask
  task test_cc;
    begin
      low_cnt = 0;
      frame(8'h80, 40, 16'h3fff, 1'b0);
      // Any 40 cycles hold three compensation cycles, from one period or split over two
      check(low_cnt >= 3, 1'b1);
    end
  endtask
  // Over 160 idle cycles: 5 gearbox slots, 12 compensation cycles, one shared
  task test_pause;
    int i;
    begin
      low_cnt = 0;
      for (i = 0; i < 160; i = i + 1) begin
        if (!tx_ready) low_cnt = low_cnt + 1;
        @(negedge clk_sys_in);
      end
      check(low_cnt, 16);
    end
  endtask
  task test_crc;
    int i;
    logic [127:0] e;
    begin
      crc_sel = 1'b1;
      send(pat(8'h60), 16'h000f, 1'b1);
      send(pat(8'h70), 16'hffff, 1'b0);
      send(pat(8'h80), 16'h0fff, 1'b1);
      tx_valid = 1'b0;
      i = 0;
      while (u_crc.rx_cnt < 3 && i < 200) begin
        @(negedge clk_sys_in);
        i = i + 1;
      end
      check(u_crc.rx_cnt, 3);
      e = pat(8'h60) & mask(16'h000f);
      e[32 +: 32] = crc_ref(`FSLUI_CRC_INIT, pat(8'h60), 4);
      check(u_crc.rx_data[0] & mask(16'h00ff), e);
      check(u_crc.rx_keep[0], 16'h00ff);
      check(u_crc.rx_data[1], pat(8'h70));
      e = pat(8'h80) & mask(16'h0fff);
      e[96 +: 32] = crc_ref(crc_ref(`FSLUI_CRC_INIT, pat(8'h70), 16), pat(8'h80), 12);
      check(u_crc.rx_data[2], e);
      check(u_crc.rx_keep[2], 16'hffff);
      check({u_crc.rx_last[0], u_crc.rx_last[1], u_crc.rx_last[2]}, 3'b101);
      crc_sel = 1'b0;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    check(blk[65:64], 2'b10);
    test_full;
    test_gap;
    test_keeps;
    test_cc;
    test_pause;
    test_crc;
    test_done;
  end
endmodule // fslui_link_user_if_tb
`default_nettype wire

// File: fslui_monitor.sv
// Port checker for the framed stream link user interface.
// Assumes one clock domain and an asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module fslui_monitor #(
  parameter        CRC_EN    = 0,
  parameter [13:0] CC_PERIOD = 14'd40
) (
  input wire logic         clk_sys_in,
  input wire logic         reset_in,
  input wire logic [15:0]  s_axi_tx_tkeep_in,
  input wire logic         s_axi_tx_tlast_in,
  input wire logic         s_axi_tx_tvalid_in,
  input wire logic         s_axi_tx_tready_out,
  input wire logic [131:0] tx_blk_out,
  input wire logic         tx_blk_valid_out,
  input wire logic [15:0]  m_axi_rx_tkeep_out,
  input wire logic         m_axi_rx_tlast_out,
  input wire logic         m_axi_rx_tvalid_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire        acc = s_axi_tx_tvalid_in && s_axi_tx_tready_out;
  logic [5:0] hi_cnt_r;
  // Counts consecutive ready cycles; the gearbox slot must break the run
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) hi_cnt_r <= 6'h0;
    else hi_cnt_r <= s_axi_tx_tready_out ? hi_cnt_r + 6'h1 : 6'h0;
  end
  gb_slot_a: assert property ($fell(tx_blk_valid_out) |=> tx_blk_valid_out ##31 !tx_blk_valid_out)
    else $error("gearbox slot spacing wrong");
  ready_run_a: assert property (hi_cnt_r <= 6'h20)
    else $error("ready high too long");
  ready_gap_a: assert property ($fell(s_axi_tx_tready_out) |-> ##[1:6] s_axi_tx_tready_out)
    else $error("ready pause too long");
  full_sep_a: assert property (acc && s_axi_tx_tlast_in && s_axi_tx_tkeep_in == 16'hffff |=> !s_axi_tx_tready_out)
    else $error("no separator slot after full beat");
  hdr_legal_a: assert property (tx_blk_out[65] != tx_blk_out[64] && tx_blk_out[131] != tx_blk_out[130])
    else $error("illegal block header");
  data_cause_a: assert property (tx_blk_valid_out && tx_blk_out[65:64] == 2'b01 |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
    else $error("data block without accepted beat");
  rx_last_a: assert property (m_axi_rx_tlast_out |-> m_axi_rx_tvalid_out)
    else $error("receive last without valid");
  rx_keep_a: assert property (m_axi_rx_tvalid_out && !m_axi_rx_tlast_out |-> m_axi_rx_tkeep_out == 16'hffff)
    else $error("receive keep not full mid frame");
  rx_pack_a: assert property (m_axi_rx_tvalid_out && m_axi_rx_tlast_out |->
    m_axi_rx_tkeep_out[0] && ((m_axi_rx_tkeep_out + 16'h1) & m_axi_rx_tkeep_out) == 16'h0)
    else $error("receive keep not packed");
endmodule // fslui_monitor
bind fslui_link_user_if fslui_monitor #(.CRC_EN(CRC_EN), .CC_PERIOD(CC_PERIOD)) u_mon (
  .clk_sys_in(clk_sys_in),
  .reset_in(reset_in),
  .s_axi_tx_tkeep_in(s_axi_tx_tkeep_in),
  .s_axi_tx_tlast_in(s_axi_tx_tlast_in),
  .s_axi_tx_tvalid_in(s_axi_tx_tvalid_in),
  .s_axi_tx_tready_out(s_axi_tx_tready_out),
  .tx_blk_out(tx_blk_out),
  .tx_blk_valid_out(tx_blk_valid_out),
  .m_axi_rx_tkeep_out(m_axi_rx_tkeep_out),
  .m_axi_rx_tlast_out(m_axi_rx_tlast_out),
  .m_axi_rx_tvalid_out(m_axi_rx_tvalid_out)
);
`default_nettype wire

// File: fslui_scrambler.v
// Self-synchronising 64-bit scrambler for one lane, x^58 + x^39 + 1.
// Assumes byte 0 at bits [7:0], sent most significant bit first.
`timescale 1ns/1ps
`default_nettype none
`include "fslui_defines.vh"

module fslui_scrambler #(
  parameter DESCRAMBLE = 0
) (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        reset_in,
  // Payload
  input  wire        en_in,
  input  wire [63:0] data_in,
  output reg  [63:0] data_out
);

  reg [57:0] state_r;
  reg [57:0] st;
  reg [63:0] res;
  reg        fb;
  integer    k;
  integer    b;

  // Bit order follows the line: byte 0 first, its bit 7 first
  always @* begin
    st  = state_r;
    res = 64'h0;
    fb  = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      for (b = 7; b >= 0; b = b - 1) begin
        fb = data_in[8*k+b] ^ st[38] ^ st[57];
        res[8*k+b] = fb;
        st = {st[56:0], (DESCRAMBLE != 0) ? data_in[8*k+b] : fb};
      end
    end
  end

  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_r  <= `FSLUI_SCR_SEED;
      data_out <= 64'h0;
    end else if (en_in) begin
      state_r  <= st;
      data_out <= res;
    end
  end

endmodule // fslui_scrambler
`default_nettype wire

// File: fslui_user_model.sv
// User-side receive sink that logs the first 64 beats the link presents.
// Assumes beats arrive on clk_sys_in with no back-pressure.
`timescale 1ns/1ps
`default_nettype none
module fslui_user_model (
  // Receive stream from the link
  input wire logic         clk_sys_in,
  input wire logic [127:0] rx_tdata_in,
  input wire logic [15:0]  rx_tkeep_in,
  input wire logic         rx_tlast_in,
  input wire logic         rx_tvalid_in
);
  logic [127:0] rx_data [0:63];
  logic [15:0]  rx_keep [0:63];
  logic         rx_last [0:63];
  int           rx_cnt = 0;
  // No ready exists, so a beat is lost unless it lands here at once
  always @(posedge clk_sys_in) begin
    if (rx_tvalid_in === 1'b1 && rx_cnt < 64) begin
      rx_data[rx_cnt] <= rx_tdata_in;
      rx_keep[rx_cnt] <= rx_tkeep_in;
      rx_last[rx_cnt] <= rx_tlast_in;
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule // fslui_user_model
`default_nettype wire
